//--- host_chan_pkg.sv
package host_chan_pkg;

   // Configuration indices reached through the index/data pair.
   localparam logic [7:0] IDX_BASE_LO = 8'h4A;
   localparam logic [7:0] IDX_BASE_HI = 8'h4B;
   localparam logic [7:0] IDX_CLK_HI = 8'h50;
   localparam logic [7:0] IDX_CLK_LO = 8'h51;
   localparam logic [7:0] IDX_KBD_HI = 8'h52;
   localparam logic [7:0] IDX_KBD_LO = 8'h53;
   localparam logic [7:0] IDX_PWR_HI = 8'h54;
   localparam logic [7:0] IDX_PWR_LO = 8'h55;
   localparam logic [7:0] IDX_FEN = 8'h56;
   localparam logic [7:0] IDX_FLOCK = 8'h57;

   // Reset values of the channel address bytes (legacy ports).
   localparam logic [7:0] CLK_HI_RST = 8'h00;
   localparam logic [7:0] CLK_LO_RST = 8'h70;
   localparam logic [7:0] KBD_HI_RST = 8'h00;
   localparam logic [7:0] KBD_LO_RST = 8'h60;
   localparam logic [7:0] PWR_HI_RST = 8'h00;
   localparam logic [7:0] PWR_LO_RST = 8'h62;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Bits forced to zero in the low address bytes.
   localparam logic [7:0] BASE_LO_MASK = 8'hFE;
   localparam logic [7:0] CLK_LO_MASK = 8'hFE;
   localparam logic [7:0] KBD_LO_MASK = 8'hFB;
   localparam logic [7:0] PWR_LO_MASK = 8'hFB;

   // Channel numbering shared by enable and lock bits.
   localparam int CH_CLK = 0;
   localparam int CH_KBD = 1;
   localparam int CH_PWR = 2;
   localparam int NUM_CH = 3;
   // Base lock is held internally at bit 3 and shown at bit 7.
   localparam int LK_BASE = 3;
   localparam int LK_BASE_POS = 7;
   localparam logic [NUM_CH-1:0] FEN_ALL = 3'h7;
   localparam logic [NUM_CH-1:0] FEN_NONE = 3'h0;
   localparam logic [3:0] FLOCK_RST = 4'h0;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic [7:0] index;
      logic [7:0] base_hi;
      logic [7:0] base_lo;
      logic [7:0] base_tmp;
      logic base_valid;
      logic [7:0] clk_hi;
      logic [7:0] clk_lo;
      logic [7:0] kbd_hi;
      logic [7:0] kbd_lo;
      logic [7:0] pwr_hi;
      logic [7:0] pwr_lo;
      logic [NUM_CH-1:0] fen;
      logic [3:0] flock;
      logic [7:0] rdata;
   } chan_state_t;

endpackage

//--- host_channel_address_decode.sv
`timescale 1ns/10ps
// What this block does
// - Base high byte holds host address bits 15..8; undefined until setup loads.
// - Base low byte bit 0 is always zero, reads zero, ignores writes.
// - After setup, base bytes change only while base lock is clear.
// - Clock channel high byte maps bits 15..8, resets 00h, lock protected.
// - Clock channel low bit 0 reads zero, ignores writes, skipped in decode.
// - Clock select low on programmed address or next one when enabled.
// - Clock channel resets to ports 0070h/0071h, enable from strap.
// - Keyboard bytes reset to 00h and 60h, writable only while unlocked.
// - Keyboard low bit 2 reads zero, ignores writes, skipped in decode.
// - Keyboard select low on programmed address or plus four when enabled.
// - Keyboard channel resets to ports 0060h/0064h, enable from strap.
// - Power bytes reset to 00h and 62h, writable only while unlocked.
// - Power low bit 2 reads zero, ignores writes, skipped in decode.
// - Power select low on programmed address or plus four when enabled.
// - Power channel resets to ports 0062h/0066h, enable from strap.
// - Strap sampled in reset: zero clears enables, one sets them all.
// - Enable bits 0,1,2 gate clock, keyboard and power selects.
// - Lock register clears on reset; writing one sets a sticky bit.
// - A set lock makes its address bytes and enable bit read only.
// - Index port write picks register; data port at next address accesses it.
// - Base high write goes to a holding byte; low write commits both.
// - Base high byte lives at configuration index 4Bh.
// - Lock register lives at configuration index 57h.
module host_channel_address_decode (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Strap that picks the enable state taken at reset
   input wire logic host_default_enable_strap,
   // Initial base load from the setup protocol
   input wire logic base_load,
   input wire logic [15:0] base_load_addr,
   // Host I/O bus
   input wire host_chan_pkg::host_req_t host_req,
   output logic [7:0] host_rdata,
   // Channel chip selects, active low
   output logic clock_channel_select_n,
   output logic keyboard_channel_select_n,
   output logic power_channel_select_n,
   // Current configuration pair base for the host decoder
   output logic config_base_valid,
   output logic [15:0] config_base
);

   host_chan_pkg::chan_state_t st_r;
   host_chan_pkg::chan_state_t st_nxt;

   logic access;
   logic cfg_hit;
   logic idx_wr;
   logic data_wr;
   logic data_rd;
   logic [7:0] wd;
   logic [7:0] flock_view;
   logic [7:0] rd_mux;
   logic clk_match;
   logic kbd_match;
   logic pwr_match;

   assign access = host_req.rd | host_req.wr;
   assign wd = host_req.wdata;

   // The pair only answers once the setup protocol has placed it.
   assign cfg_hit = st_r.base_valid &&
      host_req.addr[15:1] == {st_r.base_hi, st_r.base_lo[7:1]};
   assign idx_wr = cfg_hit && !host_req.addr[0] && host_req.wr;
   assign data_wr = cfg_hit && host_req.addr[0] && host_req.wr;
   assign data_rd = cfg_hit && host_req.addr[0] && host_req.rd;

   // Lock bits placed at their visible positions, reserved bits zero.
   always_comb begin
      flock_view = host_chan_pkg::BYTE_ZERO;
      flock_view[host_chan_pkg::NUM_CH-1:0] =
         st_r.flock[host_chan_pkg::NUM_CH-1:0];
      flock_view[host_chan_pkg::LK_BASE_POS] =
         st_r.flock[host_chan_pkg::LK_BASE];
   end

   // Unknown indices read zero, so a probe of an absent register is harmless.
   always_comb begin
      unique case (st_r.index)
         host_chan_pkg::IDX_BASE_HI: rd_mux = st_r.base_hi;
         host_chan_pkg::IDX_BASE_LO: rd_mux = st_r.base_lo;
         host_chan_pkg::IDX_CLK_HI: rd_mux = st_r.clk_hi;
         host_chan_pkg::IDX_CLK_LO: rd_mux = st_r.clk_lo;
         host_chan_pkg::IDX_KBD_HI: rd_mux = st_r.kbd_hi;
         host_chan_pkg::IDX_KBD_LO: rd_mux = st_r.kbd_lo;
         host_chan_pkg::IDX_PWR_HI: rd_mux = st_r.pwr_hi;
         host_chan_pkg::IDX_PWR_LO: rd_mux = st_r.pwr_lo;
         host_chan_pkg::IDX_FEN: rd_mux = {5'h00, st_r.fen};
         host_chan_pkg::IDX_FLOCK: rd_mux = flock_view;
         default: rd_mux = host_chan_pkg::BYTE_ZERO;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      if (srst) begin
         st_nxt.index = host_chan_pkg::BYTE_ZERO;
         // The base has no defined value until setup; valid stays low.
         st_nxt.base_hi = host_chan_pkg::BYTE_ZERO;
         st_nxt.base_lo = host_chan_pkg::BYTE_ZERO;
         st_nxt.base_tmp = host_chan_pkg::BYTE_ZERO;
         st_nxt.base_valid = 1'b0;
         st_nxt.clk_hi = host_chan_pkg::CLK_HI_RST;
         st_nxt.clk_lo = host_chan_pkg::CLK_LO_RST;
         st_nxt.kbd_hi = host_chan_pkg::KBD_HI_RST;
         st_nxt.kbd_lo = host_chan_pkg::KBD_LO_RST;
         st_nxt.pwr_hi = host_chan_pkg::PWR_HI_RST;
         st_nxt.pwr_lo = host_chan_pkg::PWR_LO_RST;
         st_nxt.fen = host_default_enable_strap ? host_chan_pkg::FEN_ALL :
            host_chan_pkg::FEN_NONE;
         st_nxt.flock = host_chan_pkg::FLOCK_RST;
         st_nxt.rdata = host_chan_pkg::BYTE_ZERO;
      end else begin
         // First placement of the pair; later moves use the two-write path.
         if (base_load && !st_r.base_valid) begin
            st_nxt.base_hi = base_load_addr[15:8];
            st_nxt.base_lo = base_load_addr[7:0] &
               host_chan_pkg::BASE_LO_MASK;
            st_nxt.base_valid = 1'b1;
         end
         if (idx_wr) begin
            st_nxt.index = wd;
         end
         if (data_rd) begin
            st_nxt.rdata = rd_mux;
         end else if (host_req.rd && cfg_hit) begin
            st_nxt.rdata = st_r.index;
         end
         if (data_wr) begin
            unique case (st_r.index)
               host_chan_pkg::IDX_BASE_HI: begin
                  if (!st_r.flock[host_chan_pkg::LK_BASE]) begin
                     st_nxt.base_tmp = wd;
                  end
               end
               host_chan_pkg::IDX_BASE_LO: begin
                  if (!st_r.flock[host_chan_pkg::LK_BASE]) begin
                     st_nxt.base_hi = st_r.base_tmp;
                     st_nxt.base_lo = wd & host_chan_pkg::BASE_LO_MASK;
                  end
               end
               host_chan_pkg::IDX_CLK_HI: begin
                  if (!st_r.flock[host_chan_pkg::CH_CLK]) begin
                     st_nxt.clk_hi = wd;
                  end
               end
               host_chan_pkg::IDX_CLK_LO: begin
                  if (!st_r.flock[host_chan_pkg::CH_CLK]) begin
                     st_nxt.clk_lo = wd & host_chan_pkg::CLK_LO_MASK;
                  end
               end
               host_chan_pkg::IDX_KBD_HI: begin
                  if (!st_r.flock[host_chan_pkg::CH_KBD]) begin
                     st_nxt.kbd_hi = wd;
                  end
               end
               host_chan_pkg::IDX_KBD_LO: begin
                  if (!st_r.flock[host_chan_pkg::CH_KBD]) begin
                     st_nxt.kbd_lo = wd & host_chan_pkg::KBD_LO_MASK;
                  end
               end
               host_chan_pkg::IDX_PWR_HI: begin
                  if (!st_r.flock[host_chan_pkg::CH_PWR]) begin
                     st_nxt.pwr_hi = wd;
                  end
               end
               host_chan_pkg::IDX_PWR_LO: begin
                  if (!st_r.flock[host_chan_pkg::CH_PWR]) begin
                     st_nxt.pwr_lo = wd & host_chan_pkg::PWR_LO_MASK;
                  end
               end
               host_chan_pkg::IDX_FEN: begin
                  // Each enable bit is protected by its own channel lock.
                  for (int i = 0; i < host_chan_pkg::NUM_CH; i++) begin
                     if (!st_r.flock[i]) begin
                        st_nxt.fen[i] = wd[i];
                     end
                  end
               end
               host_chan_pkg::IDX_FLOCK: begin
                  // Ones only ever add to the lock set; zeros change nothing.
                  st_nxt.flock[host_chan_pkg::NUM_CH-1:0] =
                     st_r.flock[host_chan_pkg::NUM_CH-1:0] |
                     wd[host_chan_pkg::NUM_CH-1:0];
                  st_nxt.flock[host_chan_pkg::LK_BASE] =
                     st_r.flock[host_chan_pkg::LK_BASE] |
                     wd[host_chan_pkg::LK_BASE_POS];
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   // Address compares skip the ignored line of each channel.
   assign clk_match = host_req.addr[15:1] ==
      {st_r.clk_hi, st_r.clk_lo[7:1]};
   assign kbd_match = {host_req.addr[15:3], host_req.addr[1:0]} ==
      {st_r.kbd_hi, st_r.kbd_lo[7:3], st_r.kbd_lo[1:0]};
   assign pwr_match = {host_req.addr[15:3], host_req.addr[1:0]} ==
      {st_r.pwr_hi, st_r.pwr_lo[7:3], st_r.pwr_lo[1:0]};

   // Selects follow the live cycle so the channel sees the same strobe.
   assign clock_channel_select_n =
      !(access && clk_match && st_r.fen[host_chan_pkg::CH_CLK]);
   assign keyboard_channel_select_n =
      !(access && kbd_match && st_r.fen[host_chan_pkg::CH_KBD]);
   assign power_channel_select_n =
      !(access && pwr_match && st_r.fen[host_chan_pkg::CH_PWR]);

   assign host_rdata = st_r.rdata;
   assign config_base_valid = st_r.base_valid;
   assign config_base = {st_r.base_hi, st_r.base_lo};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // Steps of a base relocation, each one accepted host cycle.
   sequence s_base_hi_wr;
      data_wr && st_r.index == host_chan_pkg::IDX_BASE_HI &&
         !st_r.flock[host_chan_pkg::LK_BASE];
   endsequence

   sequence s_idx_to_lo;
      idx_wr && wd == host_chan_pkg::IDX_BASE_LO;
   endsequence

   sequence s_base_lo_wr;
      data_wr && st_r.index == host_chan_pkg::IDX_BASE_LO &&
         !st_r.flock[host_chan_pkg::LK_BASE];
   endsequence

   // The holding byte alone takes the high write; the pair stays put.
   a_base_tmp_load: assert property (
      s_base_hi_wr |=> st_r.base_tmp == $past(wd))
      else $error("base high write not held in holding byte");

   a_index_load: assert property (
      s_idx_to_lo |=> st_r.index == host_chan_pkg::IDX_BASE_LO)
      else $error("index port write not taken");

   a_base_commit_pair: assert property (
      s_base_lo_wr |=>
         st_r.base_hi == $past(st_r.base_tmp) &&
         st_r.base_lo == ($past(wd) & host_chan_pkg::BASE_LO_MASK))
      else $error("base pair not committed by low write");

   a_base_hi_held: assert property (
      s_base_hi_wr |=> st_r.base_hi == $past(st_r.base_hi))
      else $error("base high changed before low write");

   a_low_bits_zero: assert property (
      !st_r.base_lo[0] && !st_r.clk_lo[0] && !st_r.kbd_lo[2] &&
         !st_r.pwr_lo[2])
      else $error("forced zero address bit is set");

   // A lock bit may only ever rise between resets.
   a_lock_sticky: assert property (
      !$past(srst) |->
         (st_r.flock & $past(st_r.flock)) == $past(st_r.flock))
      else $error("lock bit cleared without reset");

   a_locked_clock_hold: assert property (
      !$past(srst) && $past(st_r.flock[host_chan_pkg::CH_CLK]) |->
         $stable(st_r.clk_hi) && $stable(st_r.clk_lo) &&
         $stable(st_r.fen[host_chan_pkg::CH_CLK]))
      else $error("locked clock channel configuration changed");

   a_reset_defaults: assert property (
      $past(srst) |-> st_r.clk_lo == host_chan_pkg::CLK_LO_RST &&
         st_r.kbd_lo == host_chan_pkg::KBD_LO_RST &&
         st_r.pwr_lo == host_chan_pkg::PWR_LO_RST &&
         st_r.flock == host_chan_pkg::FLOCK_RST &&
         st_r.fen == ($past(host_default_enable_strap) ?
            host_chan_pkg::FEN_ALL : host_chan_pkg::FEN_NONE))
      else $error("reset defaults wrong");

   a_clock_select: assert property (
      !clock_channel_select_n == (access &&
         st_r.fen[host_chan_pkg::CH_CLK] &&
         (host_req.addr == {st_r.clk_hi, st_r.clk_lo} ||
          host_req.addr == ({st_r.clk_hi, st_r.clk_lo} | 16'h0001))))
      else $error("clock select decode wrong");

   a_keyboard_select: assert property (
      access && st_r.fen[host_chan_pkg::CH_KBD] &&
         (host_req.addr == {st_r.kbd_hi, st_r.kbd_lo} ||
          host_req.addr == {st_r.kbd_hi, st_r.kbd_lo} + 16'h0004) |->
         !keyboard_channel_select_n)
      else $error("keyboard select missing");

   a_power_select_off: assert property (
      !st_r.fen[host_chan_pkg::CH_PWR] |-> power_channel_select_n)
      else $error("power select while disabled");

   a_enable_readback: assert property (
      data_rd && st_r.index == host_chan_pkg::IDX_FEN |=>
         host_rdata == {5'h00, $past(st_r.fen)})
      else $error("enable register read wrong");

   a_locked_kbd_hold: assert property (
      !$past(srst) && $past(st_r.flock[host_chan_pkg::CH_KBD]) |->
         $stable(st_r.kbd_hi) && $stable(st_r.kbd_lo) &&
         $stable(st_r.fen[host_chan_pkg::CH_KBD]))
      else $error("locked keyboard channel configuration changed");

   a_locked_pwr_hold: assert property (
      !$past(srst) && $past(st_r.flock[host_chan_pkg::CH_PWR]) |->
         $stable(st_r.pwr_hi) && $stable(st_r.pwr_lo) &&
         $stable(st_r.fen[host_chan_pkg::CH_PWR]))
      else $error("locked power channel configuration changed");

   a_locked_base_hold: assert property (
      !$past(srst) && $past(st_r.flock[host_chan_pkg::LK_BASE]) |->
         $stable(st_r.base_hi) && $stable(st_r.base_lo))
      else $error("locked configuration base changed");

   a_base_valid_kept: assert property (
      st_r.base_valid |=> st_r.base_valid)
      else $error("configuration base lost without reset");

   a_base_reset_invalid: assert property (
      $past(srst) |-> !st_r.base_valid)
      else $error("configuration base valid straight after reset");

   a_power_select: assert property (
      access && st_r.fen[host_chan_pkg::CH_PWR] &&
         (host_req.addr == {st_r.pwr_hi, st_r.pwr_lo} ||
          host_req.addr == {st_r.pwr_hi, st_r.pwr_lo} + 16'h0004) |->
         !power_channel_select_n)
      else $error("power select missing");

   a_keyboard_select_off: assert property (
      !st_r.fen[host_chan_pkg::CH_KBD] |-> keyboard_channel_select_n)
      else $error("keyboard select while disabled");

   // Selects must never glitch low on an idle or released bus.
   a_idle_no_select: assert property (
      !access |-> clock_channel_select_n && keyboard_channel_select_n &&
         power_channel_select_n)
      else $error("channel select without a host cycle");

   a_lock_readback: assert property (
      data_rd && st_r.index == host_chan_pkg::IDX_FLOCK |=>
         host_rdata[host_chan_pkg::NUM_CH-1:0] ==
            $past(st_r.flock[host_chan_pkg::NUM_CH-1:0]) &&
         host_rdata[host_chan_pkg::LK_BASE_POS] ==
            $past(st_r.flock[host_chan_pkg::LK_BASE]) &&
         host_rdata[host_chan_pkg::LK_BASE_POS-1:host_chan_pkg::NUM_CH] ==
            '0)
      else $error("lock register read wrong");

   // Read data must stand until the next read of the pair.
   a_rdata_hold: assert property (
      !(host_req.rd && cfg_hit) |=> $stable(host_rdata))
      else $error("read data changed without a pair read");

   // A read at the even pair address returns the index itself.
   a_index_read: assert property (
      host_req.rd && cfg_hit && !host_req.addr[0] |=>
         host_rdata == $past(st_r.index))
      else $error("index port read wrong");

   // Absent registers read zero rather than echoing a neighbour.
   a_unknown_zero: assert property (
      data_rd && st_r.index > host_chan_pkg::IDX_FLOCK |=>
         host_rdata == host_chan_pkg::BYTE_ZERO)
      else $error("unknown index read not zero");

endmodule

//--- host_channel_address_decode_tb.sv
`timescale 1ns/10ps
module host_channel_address_decode_tb;
   logic clk, srst, strap, base_load, cs_clk, cs_kbd, cs_pwr, bvalid;
   logic [15:0] base_load_addr, cbase;
   logic [7:0] rdata, d;
   logic [2:0] s;
   host_chan_pkg::host_req_t req;
   int n_errors, n_checks;
   logic [15:0] pa [14] = '{16'h0070, 16'h0071, 16'h0072, 16'h0060,
      16'h0064, 16'h0062, 16'h0066, 16'h1280, 16'h1281, 16'h1282,
      16'h00FB, 16'h00FF, 16'h0002, 16'h0006};
   logic [2:0] pe [14] = '{3'h6, 3'h6, 3'h7, 3'h5, 3'h5, 3'h3, 3'h3,
      3'h6, 3'h6, 3'h7, 3'h5, 3'h5, 3'h3, 3'h3};
   logic [7:0] rv [8] = '{8'h00, 8'h70, 8'h00, 8'h60, 8'h00, 8'h62,
      8'h07, 8'h00};

   initial clk = 1'b0;
   always #50 clk = ~clk;

   host_channel_address_decode dut (.clk(clk), .srst(srst),
      .host_default_enable_strap(strap), .base_load(base_load),
      .base_load_addr(base_load_addr), .host_req(req), .host_rdata(rdata),
      .clock_channel_select_n(cs_clk), .keyboard_channel_select_n(cs_kbd),
      .power_channel_select_n(cs_pwr), .config_base_valid(bvalid),
      .config_base(cbase));
   host_model host (.clk(clk), .rdata(rdata),
      .sel_n({cs_pwr, cs_kbd, cs_clk}), .req(req));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic reset_dut(input logic st);
      @(negedge clk);
      strap = st;
      srst = 1'b1;
      repeat (12) @(negedge clk);
      srst = 1'b0;
   endtask

   // The setup load is a one-cycle pulse; its answer is awaited briefly.
   task automatic load_base(input logic [15:0] a);
      int i;
      @(negedge clk);
      base_load = 1'b1;
      base_load_addr = a;
      @(negedge clk);
      base_load = 1'b0;
      base_load_addr = ~a;
      for (i = 0; i < 4 && bvalid !== 1'b1; i++) @(negedge clk);
      host.pair_base = {a[15:1], 1'b0};
      if (bvalid !== 1'b1) begin
         n_errors++;
         test_done();
      end
   endtask

   task automatic probe_chk(input int k, input logic [2:0] exp);
      host.probe(pa[k], s);
      check(16'(s), 16'(exp));
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      host.cfg_rd(idx, d);
      check(16'(d), 16'(exp));
   endtask

   initial begin
      srst = 1'b1;
      strap = 1'b1;
      base_load = 1'b0;
      base_load_addr = 16'h0000;
      n_errors = 0;
      n_checks = 0;
      reset_dut(1'b1);
      for (int k = 0; k < 7; k++) probe_chk(k, pe[k]);
      load_base(16'h0301);
      check(cbase, 16'h0300);
      for (int k = 0; k < 8; k++) rd_chk(8'h50 + 8'(k), rv[k]);
      host.cfg_wr(8'h50, 8'h12);
      host.cfg_wr(8'h51, 8'h81);
      host.cfg_wr(8'h53, 8'hFF);
      host.cfg_wr(8'h55, 8'h06);
      rd_chk(8'h50, 8'h12);
      rd_chk(8'h51, 8'h80);
      rd_chk(8'h53, 8'hFB);
      rd_chk(8'h55, 8'h02);
      for (int k = 7; k < 14; k++) probe_chk(k, pe[k]);
      host.cfg_wr(8'h56, 8'hFA);
      rd_chk(8'h56, 8'h02);
      probe_chk(7, 3'h7);
      probe_chk(12, 3'h7);
      probe_chk(10, 3'h5);
      host.cfg_wr(8'h57, 8'h79);
      rd_chk(8'h57, 8'h01);
      host.cfg_wr(8'h50, 8'h34);
      host.cfg_wr(8'h56, 8'hFF);
      host.cfg_wr(8'h57, 8'h00);
      rd_chk(8'h50, 8'h12);
      rd_chk(8'h56, 8'h06);
      rd_chk(8'h57, 8'h01);
      host.relocate(16'h0411, d);
      check(16'(d), 16'h0003);
      check(cbase, 16'h0410);
      rd_chk(8'h56, 8'h06);
      host.bus(1'b1, 1'b0, host.pair_base, 8'h00);
      check(16'(rdata), 16'h0056);
      rd_chk(8'h58, 8'h00);
      host.cfg_wr(8'h57, 8'h86);
      rd_chk(8'h57, 8'h87);
      host.cfg_wr(8'h52, 8'hAA);
      rd_chk(8'h52, 8'h00);
      host.relocate(16'h0500, d);
      check(16'(d), 16'h0004);
      host.pair_base = 16'h0410;
      check(cbase, 16'h0410);
      reset_dut(1'b0);
      check(16'(bvalid), 16'h0000);
      for (int k = 0; k < 7; k++) probe_chk(k, 3'h7);
      load_base(16'h0200);
      rd_chk(8'h56, 8'h00);
      rd_chk(8'h57, 8'h00);
      test_done();
   end
endmodule

//--- host_model.sv
`timescale 1ns/10ps
module host_model (
   // Clock
   input wire logic clk,
   // Answers from the device
   input wire logic [7:0] rdata,
   input wire logic [2:0] sel_n,
   // Host I/O requests
   output host_chan_pkg::host_req_t req
);
   logic [15:0] pair_base;

   initial begin
      req = '0;
      pair_base = 16'h0000;
   end

   // The strobe stands across one rising edge. The released bus shows the
   // inverse, so that a stale address can never pass for a held one.
   task automatic bus(input logic r, input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      @(negedge clk);
      req <= '{addr: a, rd: r, wr: w, wdata: d};
      @(negedge clk);
      req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
   endtask

   task automatic probe(input logic [15:0] a, output logic [2:0] s);
      @(negedge clk);
      req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      #10;
      s = sel_n;
      @(negedge clk);
      req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: 8'hFF};
   endtask

   task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b0, 1'b1, pair_base, idx);
      bus(1'b0, 1'b1, pair_base | 16'h0001, d);
   endtask

   task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
      bus(1'b0, 1'b1, pair_base, idx);
      bus(1'b1, 1'b0, pair_base | 16'h0001, 8'h00);
      d = rdata;
   endtask

   // High byte first, then low byte; mid is the high byte read in between.
   task automatic relocate(input logic [15:0] a, output logic [7:0] mid);
      cfg_wr(host_chan_pkg::IDX_BASE_HI, a[15:8]);
      cfg_rd(host_chan_pkg::IDX_BASE_HI, mid);
      cfg_wr(host_chan_pkg::IDX_BASE_LO, a[7:0]);
      pair_base = {a[15:1], 1'b0};
   endtask
endmodule
